// [hdl/dsr_pkg.sv]
package dsr_pkg;

  // Register geometry
  localparam int REG_W = 8;                          // Byte-wide registers
  localparam int NREG  = 16;                         // Slots per channel

  typedef logic [3:0]       dsr_idx_t;               // Register slot index
  typedef logic [REG_W-1:0] dsr_byte_t;              // One register byte
  typedef logic [2:0]       dsr_code_t;              // Command code field

  // Write register slots
  localparam dsr_idx_t IDX_CMD     = 4'h0;           // command_pointer_reg
  localparam dsr_idx_t IDX_VEC     = 4'h2;           // interrupt_vector_wreg, shared
  localparam dsr_idx_t IDX_RXP     = 4'h3;           // rx_param_ctrl_reg
  localparam dsr_idx_t IDX_MODE    = 4'h4;           // txrx_mode_reg
  localparam dsr_idx_t IDX_TXP     = 4'h5;           // tx_param_ctrl_reg
  localparam dsr_idx_t IDX_SYNC2   = 4'h7;           // Second sync register, also extended slot
  localparam dsr_idx_t IDX_TXBUF   = 4'h8;           // Transmit buffer
  localparam dsr_idx_t IDX_MASTER  = 4'h9;           // master_irq_reset_reg, shared
  localparam dsr_idx_t IDX_MISC    = 4'hA;           // misc_txrx_ctrl_reg
  localparam dsr_idx_t IDX_BAUD_LO = 4'hC;           // baud_tc_low_reg
  localparam dsr_idx_t IDX_BAUD_HI = 4'hD;           // baud_tc_high_reg
  localparam dsr_idx_t IDX_ESEN    = 4'hF;           // External status enable register

  // Read register slots
  localparam dsr_idx_t RD_STAT0    = 4'h0;           // Buffer and external status
  localparam dsr_idx_t RD_SPEC     = 4'h1;           // Special receive status
  localparam dsr_idx_t RD_VEC      = 4'h2;           // vector_readback_reg
  localparam dsr_idx_t RD_PEND     = 4'h3;           // irq_pending_status_reg
  localparam dsr_idx_t RD_MODE     = 4'h4;           // Mode readback
  localparam dsr_idx_t RD_TXP      = 4'h5;           // Tx parameter readback
  localparam dsr_idx_t RD_FCNT_LO  = 4'h6;           // frame_count_low_status
  localparam dsr_idx_t RD_FCNT_HI  = 4'h7;           // frame_count_high_status
  localparam dsr_idx_t RD_RXBUF    = 4'h8;           // Receive buffer
  localparam dsr_idx_t RD_RXP      = 4'h9;           // rx_param_readback
  localparam dsr_idx_t RD_MSTAT    = 4'hA;           // Miscellaneous status
  localparam dsr_idx_t RD_MISC     = 4'hB;           // misc_ctrl_readback
  localparam dsr_idx_t RD_BAUD_LO  = 4'hC;           // Baud constant low readback
  localparam dsr_idx_t RD_BAUD_HI  = 4'hD;           // Baud constant high readback
  localparam dsr_idx_t RD_EXT      = 4'hE;           // extended_feature_readback
  localparam dsr_idx_t RD_ESEN     = 4'hF;           // External status enable readback

  // Command register fields
  localparam int        PTR_LSB        = 0;          // Register pointer bits
  localparam int        PTR_MSB        = 2;
  localparam int        CMD_LSB        = 3;          // Command code bits
  localparam int        CMD_MSB        = 5;
  localparam int        CRC_LSB        = 6;          // CRC reset code bits
  localparam int        CRC_MSB        = 7;
  localparam dsr_code_t CMD_POINT_HIGH = 3'h1;       // Point-high command
  localparam dsr_idx_t  PTR_HIGH_OFS   = 4'h8;       // Added by point-high

  // Other field positions
  localparam int        EXT_READ_BIT   = 6;          // Extended read enable
  localparam int        ESEN_EXT_BIT   = 0;          // Steer slot 7 to extended reg
  localparam int        ESEN_FFIFO_BIT = 2;          // Frame status FIFO enable
  localparam int        MODE_SYN_LSB   = 4;          // Sync sub-mode field
  localparam int        MODE_SYN_MSB   = 5;
  localparam int        MODE_STP_LSB   = 2;          // Stop bits field, zero for sync
  localparam int        MODE_STP_MSB   = 3;
  localparam logic [1:0] MODE_SDLC     = 2'h2;       // Bit-oriented sub-mode
  localparam logic [1:0] MODE_SYNC     = 2'h0;       // Synchronous stop code
  localparam int        VEC_ST_LSB     = 1;          // Status overlay in vector
  localparam int        VEC_ST_MSB     = 3;
  localparam int        PEND_W         = 3;          // Pending bits per channel

  // Reset and storage values
  localparam dsr_byte_t RST_BYTE       = 8'h00;      // Every register clears
  localparam dsr_byte_t MASK_FULL      = 8'hFF;      // All bits present
  localparam dsr_byte_t MASK_EXT       = 8'h7F;      // Top bit of extended reg absent

  // Bits physically present in each write slot
  function automatic dsr_byte_t impl_mask(input dsr_idx_t idx, input logic ext);
    impl_mask = (ext && idx == IDX_SYNC2) ? MASK_EXT : MASK_FULL;
  endfunction

endpackage

// [hdl/dsr_wr_if.sv]
`timescale 1ns/1ps
interface dsr_wr_if;
  import dsr_pkg::*;
  logic      wr;                                     // One-cycle write strobe
  logic      chan_b;                                 // Target channel, 1 = B
  dsr_idx_t  idx;                                    // Decoded register slot
  dsr_byte_t data;                                   // Write data

  modport src (output wr, output chan_b, output idx, output data);
  modport dst (input wr, input chan_b, input idx, input data);
endinterface

// [hdl/dsr_ptr_decode.sv]
`timescale 1ns/1ps
module dsr_ptr_decode
  import dsr_pkg::*;
(
  input  wire logic      i_ref_clk,
  input  wire logic      i_rst_n,
  input  wire logic      i_direct,                   // 1 = direct-addressed bus variant
  input  wire logic      i_access,                   // Read or write taken this cycle
  input  wire logic      i_wr,                       // Access is a write
  input  wire logic      i_data_port,                // Pointer variant: data port access
  input  wire dsr_idx_t  i_addr,                     // Direct variant slot address
  input  wire dsr_byte_t i_wdata,
  output dsr_idx_t       o_idx,                      // Slot of the current access
  output dsr_idx_t       o_ptr                       // Pointer held for next access
);

  // Pointer is idle at zero or armed by a command write
  typedef enum logic {PT_IDLE, PT_ARMED} dsr_pt_t;

  dsr_pt_t   state_r;                                // Pointer state
  dsr_pt_t   state_nxt;
  dsr_idx_t  ptr_r;                                  // Stored pointer
  dsr_idx_t  ptr_nxt;
  dsr_code_t code;                                   // Command field of write data

  assign code  = i_wdata[CMD_MSB:CMD_LSB];
  assign o_ptr = ptr_r;

  // Slot of this access; in the pointer variant data port means buffer slot
  always_comb begin
    if (i_direct) begin
      o_idx = i_addr;
    end else if (i_data_port) begin
      o_idx = IDX_TXBUF;
    end else begin
      o_idx = ptr_r;
    end
  end

  // Next pointer; only the pointer variant decodes pointer bits
  always_comb begin
    state_nxt = state_r;
    ptr_nxt   = ptr_r;
    if (i_access && !i_direct && !i_data_port) begin
      case (state_r)
        PT_IDLE: begin
          if (i_wr) begin
            // Point-high adds eight to the written pointer, see R14
            ptr_nxt   = {1'b0, i_wdata[PTR_MSB:PTR_LSB]}
                        + ((code == CMD_POINT_HIGH) ? PTR_HIGH_OFS : IDX_CMD);
            state_nxt = (ptr_nxt == IDX_CMD) ? PT_IDLE : PT_ARMED;
          end
        end
        PT_ARMED: begin
          // One access consumes the pointer
          ptr_nxt   = IDX_CMD;
          state_nxt = PT_IDLE;
        end
        default: begin
          ptr_nxt   = IDX_CMD;
          state_nxt = PT_IDLE;
        end
      endcase
    end
  end

  // Pointer registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= PT_IDLE;
      ptr_r   <= IDX_CMD;
    end else begin
      state_r <= state_nxt;
      ptr_r   <= ptr_nxt;
    end
  end

endmodule

// [hdl/dsr_chan_bank.sv]
`timescale 1ns/1ps
module dsr_chan_bank
  import dsr_pkg::*;
#(
  parameter logic CHAN_B = 1'b0                      // Which channel this bank serves
)(
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_rst_n,
  dsr_wr_if.dst                             wr_if,
  output logic [NREG-1:0][REG_W-1:0]        o_regs,  // Per-channel write slots
  output dsr_byte_t                         o_ext    // Extended feature register
);

  logic [NREG-1:0][REG_W-1:0] regs_r;                // Slot storage
  dsr_byte_t                  ext_r;                 // extended_feature_reg
  logic                       hit;                   // Write aimed at this bank
  logic                       ext_sel;               // Slot 7 steered to extended reg

  assign hit     = wr_if.wr && (wr_if.chan_b == CHAN_B);
  assign ext_sel = regs_r[IDX_ESEN][ESEN_EXT_BIT];
  assign o_regs  = regs_r;
  assign o_ext   = ext_r;

  // Per-channel slots; shared and buffer slots live in the top
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      regs_r <= '0;
    end else if (hit && !(wr_if.idx == IDX_SYNC2 && ext_sel)
                 && wr_if.idx != IDX_VEC && wr_if.idx != IDX_MASTER
                 && wr_if.idx != IDX_TXBUF) begin
      // Present bits store, absent bits are dropped, see R11 R1 R15
      regs_r[wr_if.idx] <= wr_if.data & impl_mask(wr_if.idx, 1'b0);
    end
  end

  // Extended feature register, reached through slot 7 when steered
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_r <= RST_BYTE;
    end else if (hit && wr_if.idx == IDX_SYNC2 && ext_sel) begin
      ext_r <= wr_if.data & impl_mask(IDX_SYNC2, 1'b1); // see R1 R15
    end
  end

endmodule

// [hdl/dsr_regmap.sv]
`timescale 1ns/1ps
// Functional notes
// R1: Present reserved bits store and read back
// R2: Absent reserved bits always read zero
// R3: Host writes zero to reserved bits; t_ext writes a one to the absent extended bit
// R4: Host never issues reserved command codes
// R5: Extended read exposes slots 9,4,5,11,14
// R6: Master interrupt register shared, either channel
// R7: Interrupt vector register single, shared
// R8: Channel B reads modified vector, A raw
// R9: Pending-bit register only in channel A
// R10: Slots 6,7 only with frame FIFO
// R11: Eleven control, two sync, two baud registers
// R12: Baud constant bytes read at 12, 13
// R13: Bus variants differ only in command decode
// R14: Point-high adds eight to pointer
// R15: Writes to absent bits are discarded
module dsr_regmap
  import dsr_pkg::*;
(
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst_n,
  // Host access port
  input  wire logic                   i_direct,       // 1 = direct-addressed variant
  input  wire logic                   i_wr_en,        // Write request, one cycle
  input  wire logic                   i_rd_en,        // Read request, one cycle
  input  wire logic                   i_chan_b,       // 1 = channel B
  input  wire logic                   i_data_port,    // Pointer variant data port
  input  wire dsr_idx_t               i_addr,         // Direct variant slot
  input  wire dsr_byte_t              i_wdata,
  output dsr_byte_t                   o_rdata,        // Read data, registered
  output logic                        o_rvalid,       // Read data strobe
  // Status from the channel logic
  input  wire dsr_byte_t              i_stat0_a,
  input  wire dsr_byte_t              i_stat0_b,
  input  wire dsr_byte_t              i_spec_a,
  input  wire dsr_byte_t              i_spec_b,
  input  wire dsr_byte_t              i_mstat_a,
  input  wire dsr_byte_t              i_mstat_b,
  input  wire dsr_byte_t              i_rx_data_a,
  input  wire dsr_byte_t              i_rx_data_b,
  input  wire dsr_byte_t              i_fcnt_lo_a,
  input  wire dsr_byte_t              i_fcnt_lo_b,
  input  wire dsr_byte_t              i_fcnt_hi_a,
  input  wire dsr_byte_t              i_fcnt_hi_b,
  input  wire logic [PEND_W-1:0]      i_pend_a,       // Pending bits of channel A
  input  wire logic [PEND_W-1:0]      i_pend_b,       // Pending bits of channel B
  input  wire logic [PEND_W-1:0]      i_vec_status,   // Status code for the vector
  // Register images to the channel logic
  output logic [NREG*REG_W-1:0]       o_wregs_a,
  output logic [NREG*REG_W-1:0]       o_wregs_b,
  output dsr_byte_t                   o_ext_a,
  output dsr_byte_t                   o_ext_b,
  output dsr_byte_t                   o_vector,
  output dsr_byte_t                   o_master,
  // Command and data strobes
  output logic                        o_cmd_stb,      // Command register written
  output logic                        o_cmd_chan_b,
  output dsr_code_t                   o_cmd_code,
  output logic [CRC_MSB-CRC_LSB:0]    o_crc_code,
  output logic                        o_master_stb,   // Shared master register written
  output logic                        o_tx_stb,       // Transmit buffer loaded
  output logic                        o_tx_chan_b,
  output dsr_byte_t                   o_tx_data,
  output logic                        o_rx_rd_stb,    // Receive buffer read
  output logic                        o_rx_chan_b
);

  // Decoded access
  dsr_wr_if                    wr_bus ();             // Write path to both banks
  dsr_idx_t                    acc_idx;               // Slot of this access
  logic                        access;                // Read or write this cycle

  // Storage images
  logic [NREG-1:0][REG_W-1:0]  regs_a;                // Channel A slots
  logic [NREG-1:0][REG_W-1:0]  regs_b;                // Channel B slots
  dsr_byte_t                   ext_a;                 // Channel A extended reg
  dsr_byte_t                   ext_b;                 // Channel B extended reg
  dsr_byte_t                   vector_r;              // Shared vector register
  dsr_byte_t                   master_r;              // Shared master register

  // Read path
  dsr_byte_t                   rd_nxt;                // Selected read byte
  dsr_byte_t                   rdata_r;
  logic                        rvalid_r;
  logic                        rx_rd_r;
  logic                        rx_chan_r;

  // Per-channel views for the read mux
  logic [NREG-1:0][REG_W-1:0]  sel_regs;
  dsr_byte_t                   sel_ext;
  logic                        ext_read;              // Extended read enabled
  logic                        ffifo_on;              // Frame status FIFO enabled

  // Command strobe registers
  logic                        cmd_stb_r;
  logic                        cmd_chan_r;
  dsr_code_t                   cmd_code_r;
  logic [CRC_MSB-CRC_LSB:0]    crc_code_r;
  logic                        master_stb_r;
  logic                        tx_stb_r;
  logic                        tx_chan_r;
  dsr_byte_t                   tx_data_r;

  // One request per cycle; a write wins if both arrive
  assign access = i_wr_en || i_rd_en;

  // Pointer and address decode; the variants differ only here, see R13
  dsr_ptr_decode u_decode (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_direct    (i_direct),
    .i_access    (access),
    .i_wr        (i_wr_en),
    .i_data_port (i_data_port),
    .i_addr      (i_addr),
    .i_wdata     (i_wdata),
    .o_idx       (acc_idx),
    .o_ptr       ()
  );

  // Fan the write out to both banks
  assign wr_bus.wr     = i_wr_en;
  assign wr_bus.chan_b = i_chan_b;
  assign wr_bus.idx    = acc_idx;
  assign wr_bus.data   = i_wdata;

  // Channel A bank
  dsr_chan_bank #(
    .CHAN_B (1'b0)
  ) u_bank_a (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .wr_if     (wr_bus),
    .o_regs    (regs_a),
    .o_ext     (ext_a)
  );

  // Channel B bank
  dsr_chan_bank #(
    .CHAN_B (1'b1)
  ) u_bank_b (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .wr_if     (wr_bus),
    .o_regs    (regs_b),
    .o_ext     (ext_b)
  );

  // Shared vector register; channel address is ignored on purpose
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vector_r <= RST_BYTE;
    end else if (i_wr_en && acc_idx == IDX_VEC) begin
      vector_r <= i_wdata & impl_mask(IDX_VEC, 1'b0); // see R7 R15
    end
  end

  // Shared master register, reachable from either channel
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      master_r     <= RST_BYTE;
      master_stb_r <= 1'b0;
    end else begin
      master_stb_r <= i_wr_en && acc_idx == IDX_MASTER;
      if (i_wr_en && acc_idx == IDX_MASTER) begin
        master_r <= i_wdata & impl_mask(IDX_MASTER, 1'b0); // see R6 R15
      end
    end
  end

  // Command strobe; reset actions are carried out by the channel logic
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_stb_r  <= 1'b0;
      cmd_chan_r <= 1'b0;
      cmd_code_r <= '0;
      crc_code_r <= '0;
    end else begin
      cmd_stb_r <= i_wr_en && acc_idx == IDX_CMD;
      if (i_wr_en && acc_idx == IDX_CMD) begin
        cmd_chan_r <= i_chan_b;
        cmd_code_r <= i_wdata[CMD_MSB:CMD_LSB];
        crc_code_r <= i_wdata[CRC_MSB:CRC_LSB];
      end
    end
  end

  // Transmit buffer load; data is handed on, not stored as a slot
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_stb_r  <= 1'b0;
      tx_chan_r <= 1'b0;
      tx_data_r <= RST_BYTE;
    end else begin
      tx_stb_r <= i_wr_en && acc_idx == IDX_TXBUF;
      if (i_wr_en && acc_idx == IDX_TXBUF) begin
        tx_chan_r <= i_chan_b;
        tx_data_r <= i_wdata;
      end
    end
  end

  // Channel view for reads
  assign sel_regs = i_chan_b ? regs_b : regs_a;
  assign sel_ext  = i_chan_b ? ext_b : ext_a;
  assign ext_read = sel_ext[EXT_READ_BIT];
  // Frame counts only in bit-oriented sync mode with the FIFO enabled
  assign ffifo_on = sel_regs[IDX_ESEN][ESEN_FFIFO_BIT]
                    && sel_regs[IDX_MODE][MODE_SYN_MSB:MODE_SYN_LSB] == MODE_SDLC
                    && sel_regs[IDX_MODE][MODE_STP_MSB:MODE_STP_LSB] == MODE_SYNC;

  // Read multiplexer; unavailable slots return zero
  always_comb begin
    rd_nxt = RST_BYTE;
    case (acc_idx)
      RD_STAT0: begin
        rd_nxt = i_chan_b ? i_stat0_b : i_stat0_a;
      end
      RD_SPEC: begin
        rd_nxt = i_chan_b ? i_spec_b : i_spec_a;
      end
      RD_VEC: begin
        rd_nxt = vector_r;
        if (i_chan_b) begin
          // Status overlay only through channel B, see R8
          rd_nxt[VEC_ST_MSB:VEC_ST_LSB] = i_vec_status;
        end
      end
      RD_PEND: begin
        // Channel B has no pending register and reads zero, see R9
        if (!i_chan_b) begin
          rd_nxt = {{(REG_W-2*PEND_W){1'b0}}, i_pend_a, i_pend_b};
        end
      end
      RD_MODE: begin
        if (ext_read) rd_nxt = sel_regs[IDX_MODE]; // see R5
      end
      RD_TXP: begin
        if (ext_read) rd_nxt = sel_regs[IDX_TXP]; // see R5
      end
      RD_FCNT_LO: begin
        if (ffifo_on) rd_nxt = i_chan_b ? i_fcnt_lo_b : i_fcnt_lo_a; // see R10
      end
      RD_FCNT_HI: begin
        if (ffifo_on) rd_nxt = i_chan_b ? i_fcnt_hi_b : i_fcnt_hi_a; // see R10
      end
      RD_RXBUF: begin
        rd_nxt = i_chan_b ? i_rx_data_b : i_rx_data_a;
      end
      RD_RXP: begin
        if (ext_read) rd_nxt = sel_regs[IDX_RXP]; // see R5
      end
      RD_MSTAT: begin
        rd_nxt = i_chan_b ? i_mstat_b : i_mstat_a;
      end
      RD_MISC: begin
        if (ext_read) rd_nxt = sel_regs[IDX_MISC]; // see R5
      end
      RD_BAUD_LO: begin
        rd_nxt = sel_regs[IDX_BAUD_LO]; // see R12
      end
      RD_BAUD_HI: begin
        rd_nxt = sel_regs[IDX_BAUD_HI]; // see R12
      end
      RD_EXT: begin
        // Absent top bit was never stored, so it reads zero, see R5 R2
        if (ext_read) rd_nxt = sel_ext;
      end
      RD_ESEN: begin
        rd_nxt = sel_regs[IDX_ESEN];
      end
      default: begin
        rd_nxt = RST_BYTE;
      end
    endcase
  end

  // Registered read answer one cycle after the request
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r  <= RST_BYTE;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= i_rd_en && !i_wr_en;
      if (i_rd_en && !i_wr_en) begin
        rdata_r <= rd_nxt;
      end
    end
  end

  // Receive buffer read side effect, so the channel can pop its FIFO
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_rd_r   <= 1'b0;
      rx_chan_r <= 1'b0;
    end else begin
      rx_rd_r <= i_rd_en && !i_wr_en && acc_idx == RD_RXBUF;
      if (i_rd_en && !i_wr_en && acc_idx == RD_RXBUF) begin
        rx_chan_r <= i_chan_b;
      end
    end
  end

  // Output drive
  assign o_rdata      = rdata_r;
  assign o_rvalid     = rvalid_r;
  assign o_wregs_a    = regs_a;
  assign o_wregs_b    = regs_b;
  assign o_ext_a      = ext_a;
  assign o_ext_b      = ext_b;
  assign o_vector     = vector_r;
  assign o_master     = master_r;
  assign o_cmd_stb    = cmd_stb_r;
  assign o_cmd_chan_b = cmd_chan_r;
  assign o_cmd_code   = cmd_code_r;
  assign o_crc_code   = crc_code_r;
  assign o_master_stb = master_stb_r;
  assign o_tx_stb     = tx_stb_r;
  assign o_tx_chan_b  = tx_chan_r;
  assign o_tx_data    = tx_data_r;
  assign o_rx_rd_stb  = rx_rd_r;
  assign o_rx_chan_b  = rx_chan_r;

endmodule

// [dv/dsr_regmap_asserts.sv]
`timescale 1ns/1ps
module dsr_regmap_asserts
  import dsr_pkg::*;
(
  input wire logic      i_ref_clk,
  input wire logic      i_rst_n,
  input wire logic      i_direct,
  input wire logic      i_wr_en,
  input wire logic      i_rd_en,
  input wire logic      i_chan_b,
  input wire dsr_idx_t  i_addr,
  input wire dsr_byte_t i_wdata,
  input wire dsr_byte_t o_rdata,
  input wire dsr_byte_t o_vector,
  input wire dsr_byte_t o_master,
  input wire logic      o_master_stb,
  input wire dsr_byte_t o_ext_a,
  input wire logic      o_tx_stb,
  input wire logic      o_tx_chan_b,
  input wire dsr_byte_t o_tx_data
);
  wire logic wd = i_wr_en && i_direct;             // Direct write taken
  wire logic rd = i_rd_en && !i_wr_en && i_direct; // Direct read, write wins
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  property p_mst; wd && i_addr == IDX_MASTER |=> o_master_stb && o_master == $past(i_wdata); endproperty
  a_mst: assert property (p_mst) else $error("master write lost");
  property p_vec; wd && i_addr == IDX_VEC |=> o_vector == $past(i_wdata); endproperty
  a_vec: assert property (p_vec) else $error("vector write lost");
  property p_vch; i_direct && $changed(o_vector) |-> $past(wd) && $past(i_addr) == IDX_VEC; endproperty
  a_vch: assert property (p_vch) else $error("vector changed unasked");
  property p_va; rd && !i_chan_b && i_addr == RD_VEC |=> o_rdata == o_vector; endproperty
  a_va: assert property (p_va) else $error("vector read A modified");
  property p_vb; rd && i_chan_b && i_addr == RD_VEC |=> o_rdata[7:4] == o_vector[7:4]; endproperty
  a_vb: assert property (p_vb) else $error("vector read B upper bits");
  property p_pb; rd && i_chan_b && i_addr == RD_PEND |=> o_rdata == 8'h00; endproperty
  a_pb: assert property (p_pb) else $error("pending read on B");
  property p_x7; o_ext_a[7] == 1'b0; endproperty
  a_x7: assert property (p_x7) else $error("absent bit stored");
  property p_tx; wd && i_addr == IDX_TXBUF |=> o_tx_stb && o_tx_data == $past(i_wdata)
    && o_tx_chan_b == $past(i_chan_b); endproperty
  a_tx: assert property (p_tx) else $error("tx load lost");
endmodule
bind dsr_regmap dsr_regmap_asserts u_chk (.*);

// [dv/dsr_host_model.sv]
`timescale 1ns/1ps
module dsr_host_model
  import dsr_pkg::*;
(
  input  wire logic      i_ref_clk,
  input  wire dsr_byte_t i_rdata,
  input  wire logic      i_rvalid,
  output logic           o_wr_en,
  output logic           o_rd_en,
  output logic           o_chan_b,
  output logic           o_data_port,
  output dsr_idx_t       o_addr,
  output dsr_byte_t      o_wdata
);
  // Idle bus; callers use no reserved codes; t_ext writes a one to the absent extended bit
  initial {o_wr_en, o_rd_en, o_chan_b, o_data_port, o_addr, o_wdata} = '0;
  // One write; data port used for the buffer slot
  task automatic wr(input logic b, input dsr_idx_t a, input dsr_byte_t d);
    @(negedge i_ref_clk) {o_wr_en, o_chan_b, o_addr, o_wdata, o_data_port} = {1'b1, b, a, d, a == IDX_TXBUF};
    @(negedge i_ref_clk) o_wr_en = 1'b0;
    o_wdata = ~d; // Released data never shows a stale value
  endtask
  // One read; missing strobe yields unknown so any compare fails
  task automatic rd(input logic b, input dsr_idx_t a, output dsr_byte_t q);
    @(negedge i_ref_clk) {o_rd_en, o_chan_b, o_addr, o_data_port} = {1'b1, b, a, a == RD_RXBUF};
    @(negedge i_ref_clk) o_rd_en = 1'b0;
    q = i_rvalid ? i_rdata : 'x;
  endtask
endmodule

// [dv/tb_dsr_regmap.sv]
`timescale 1ns/1ps
module tb_dsr_regmap;
  import dsr_pkg::*;
  logic                  clk, rst_n, dir, we, re, cb, dp, rv; // Bus and control
  dsr_idx_t              ad;
  dsr_byte_t             wd, rdt, st, q, vec, mst, ext;
  logic [PEND_W-1:0]     pa, pb, vs;                          // Pending and vector status
  logic [NREG*REG_W-1:0] wa;                                  // Channel A images
  int                    errors = 0, n_checks = 0;
  dsr_host_model u_host (.i_ref_clk(clk), .i_rdata(rdt), .i_rvalid(rv), .o_wr_en(we), .o_rd_en(re),
    .o_chan_b(cb), .o_data_port(dp), .o_addr(ad), .o_wdata(wd));
  dsr_regmap dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_direct(dir), .i_wr_en(we), .i_rd_en(re), .i_chan_b(cb),
    .i_data_port(dp), .i_addr(ad), .i_wdata(wd), .o_rdata(rdt), .o_rvalid(rv), .i_stat0_a(st), .i_stat0_b(st),
    .i_spec_a(st), .i_spec_b(st), .i_mstat_a(st), .i_mstat_b(st), .i_rx_data_a(st), .i_rx_data_b(st),
    .i_fcnt_lo_a(st), .i_fcnt_lo_b(st), .i_fcnt_hi_a(~st), .i_fcnt_hi_b(~st), .i_pend_a(pa), .i_pend_b(pb),
    .i_vec_status(vs), .o_wregs_a(wa), .o_wregs_b(), .o_ext_a(ext), .o_ext_b(), .o_vector(vec), .o_master(mst),
    .o_cmd_stb(), .o_cmd_chan_b(), .o_cmd_code(), .o_crc_code(), .o_master_stb(), .o_tx_stb(), .o_tx_chan_b(),
    .o_tx_data(), .o_rx_rd_stb(), .o_rx_chan_b());
  // Compare and count
  task automatic chk(input dsr_byte_t got, input dsr_byte_t exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Read a slot and compare
  task automatic rchk(input logic b, input dsr_idx_t a, input dsr_byte_t exp);
    u_host.rd(b, a, q);
    chk(q, exp);
  endtask
  // Shared vector, master and pending registers
  task automatic t_shared();
    chk(vec, 8'h00);
    u_host.wr(1'b1, IDX_VEC, 8'hA6);
    rchk(1'b0, RD_VEC, 8'hA6);
    rchk(1'b1, RD_VEC, {4'hA, vs, 1'b0});
    u_host.wr(1'b0, IDX_MASTER, 8'h3C);
    chk(mst, 8'h3C);
    rchk(1'b0, RD_PEND, {2'b00, pa, pb});
    rchk(1'b1, RD_PEND, 8'h00);
  endtask
  // Extended readback, absent bit dropped on purpose
  task automatic t_ext();
    dsr_idx_t  wi[4] = '{IDX_RXP, IDX_MODE, IDX_TXP, IDX_MISC};
    dsr_idx_t  ri[4] = '{RD_RXP, RD_MODE, RD_TXP, RD_MISC};
    dsr_byte_t dv[4] = '{8'h9A, 8'h20, 8'h6B, 8'h3C};
    u_host.wr(1'b0, IDX_ESEN, 8'h01);
    u_host.wr(1'b0, IDX_SYNC2, 8'hC5);
    chk(ext, 8'h45);
    foreach (wi[i]) u_host.wr(1'b0, wi[i], dv[i]);
    foreach (ri[i]) rchk(1'b0, ri[i], dv[i]);
    rchk(1'b0, RD_EXT, 8'h45);
    u_host.wr(1'b0, IDX_SYNC2, 8'h05);
    rchk(1'b0, RD_RXP, 8'h00);
  endtask
  // Frame counts gated, baud readback, buffer load
  task automatic t_frame();
    rchk(1'b0, RD_FCNT_LO, 8'h00);
    u_host.wr(1'b0, IDX_ESEN, 8'h04);
    rchk(1'b0, RD_FCNT_LO, st);
    rchk(1'b0, RD_FCNT_HI, ~st);
    u_host.wr(1'b1, IDX_BAUD_LO, 8'hA5);
    u_host.wr(1'b1, IDX_BAUD_HI, 8'h5A);
    rchk(1'b1, RD_BAUD_LO, 8'hA5);
    rchk(1'b1, RD_BAUD_HI, 8'h5A);
    u_host.wr(1'b1, IDX_TXBUF, 8'h77);
  endtask
  // Pointer variant with point-high
  task automatic t_ptr();
    dir = 1'b0;
    u_host.wr(1'b0, 4'h0, 8'h0C);
    u_host.wr(1'b0, 4'h0, 8'h55);
    chk(wa[IDX_BAUD_LO*REG_W +: REG_W], 8'h55);
    u_host.wr(1'b0, 4'h0, 8'h0C);
    rchk(1'b0, 4'h0, 8'h55);
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Reset for 12 cycles, then the scenarios
  initial begin
    {rst_n, dir, st, pa, pb, vs} = {2'b01, 8'h3D, 3'h6, 3'h1, 3'h5};
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    t_shared();
    t_ext();
    t_frame();
    t_ptr();
    complete_run();
  end
  // Watchdog, far beyond the run
  initial begin
    #20000 errors++;
    complete_run();
  end
endmodule
